// file: rtl/amrs_read_seq.sv
// Purpose: read cycle sequencer for asynchronous sram and nor flash
// Assumes: one clock, system clock 0 at 100 MHz; pins synchronised by amrs_sync
// Notes:   phase counts latch when a read starts
`timescale 1ns/1ns
module amrs_read_seq #(
  parameter int unsigned AW  = 24,
  parameter int unsigned DW  = 16,
  parameter int unsigned NB  = 4,
  parameter int unsigned BEW = 2,
  parameter int unsigned CW  = 8
) (
  input  wire logic                             sys_clk_i,
  input  wire logic                             reset_n_i,
  input  wire logic [amrs_pkg::AMRS_REG_AW-1:0] reg_addr_i,
  input  wire logic [amrs_pkg::AMRS_REG_DW-1:0] reg_wdata_i,
  input  wire logic                             reg_write_i,
  input  wire logic                             reg_read_i,
  output logic      [amrs_pkg::AMRS_REG_DW-1:0] reg_rdata_o,
  output logic      [AW-1:0]                    memory_address_out_o,
  output logic      [NB-1:0]                    bank_select_n_o,
  output logic      [BEW-1:0]                   byte_enable_n_o,
  output logic                                  output_enable_n_o,
  output logic                                  read_strobe_n_o,
  output logic                                  address_valid_n_o,
  input  wire logic [DW-1:0]                    memory_data_bus_i,
  input  wire logic                             memory_ready_in_i,
  output logic                                  clock_output_pin_o
);
  import amrs_pkg::*;

  localparam int unsigned BW = (NB > 1) ? $clog2(NB) : 1;
  localparam int unsigned HW = CW + 2;

  typedef struct packed {
    logic [31:0]   ctl;
    logic [31:0]   tim;
    logic [31:0]   etim;
    logic [31:0]   rdata;
    amrs_phase_t   ph;
    logic [CW-1:0] cnt;
    logic [CW-1:0] pre;
    logic [CW-1:0] set;
    logic [CW-1:0] pac;
    logic [CW-1:0] acc;
    logic [CW-1:0] hld;
    logic          flash;
    logic          rdy_en;
    logic          rdy_seen;
    logic [BW-1:0] bank;
    logic [AW-1:0] addr;
    logic [BEW-1:0] be;
    logic [1:0]    cap;
    logic [DW-1:0] data;
    logic          valid;
    logic          rd_n;
    logic          oe_n;
    logic          adv_n;
    logic [NB-1:0] bank_n;
    logic [BEW-1:0] be_n;
    logic          clk_en;
  } amrs_state_t;

  amrs_state_t   state_reg;
  amrs_state_t   state_next;
  logic [DW-1:0] data_sync;
  logic          ready_sync;
  logic          start;

  amrs_sync #(
    .W (DW + 1)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({memory_ready_in_i, memory_data_bus_i}),
    .sync_o    ({ready_sync, data_sync})
  );

  // next phase in order, passing over phases of zero length
  function automatic amrs_phase_t next_live(input amrs_phase_t cur, input logic [CW-1:0] pre,
                                            input logic [CW-1:0] set, input logic [CW-1:0] pac,
                                            input logic [CW-1:0] hld);
    amrs_phase_t p;
    case (cur)
      AMRS_IDLE:      p = AMRS_PRESETUP;
      AMRS_PRESETUP:  p = AMRS_SETUP;
      AMRS_SETUP:     p = AMRS_PREACCESS;
      AMRS_PREACCESS: p = AMRS_ACCESS;
      AMRS_ACCESS:    p = AMRS_HOLD;
      default:        p = AMRS_IDLE;
    endcase
    if (p == AMRS_PRESETUP && pre == '0) p = AMRS_SETUP;
    if (p == AMRS_SETUP && set == '0) p = AMRS_PREACCESS;
    if (p == AMRS_PREACCESS && pac == '0) p = AMRS_ACCESS;
    if (p == AMRS_HOLD && hld == '0) p = AMRS_IDLE;
    return p;
  endfunction

  // cycles still to run in a phase after its first, counted down in cnt
  function automatic logic [CW-1:0] phase_last(input amrs_phase_t p, input amrs_state_t s);
    logic [CW-1:0] len;
    case (p)
      AMRS_PRESETUP:  len = s.pre;
      AMRS_SETUP:     len = s.set;
      AMRS_PREACCESS: len = s.pac;
      AMRS_ACCESS:    len = s.acc;
      AMRS_HOLD:      len = s.hld;
      default:        len = CW'(1);
    endcase
    return len - CW'(1);
  endfunction

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = '0;
    state_next.cap   = {state_reg.cap[0], 1'b0};
    start            = reg_write_i && (reg_addr_i == AMRS_OFF_ADDR) && (state_reg.ph == AMRS_IDLE);

    // register writes
    if (reg_write_i) begin
      case (reg_addr_i)
        AMRS_OFF_CTL:  state_next.ctl = reg_wdata_i & AMRS_CTL_MASK;
        AMRS_OFF_TIM:  state_next.tim = reg_wdata_i & AMRS_TIM_MASK;
        AMRS_OFF_ETIM: state_next.etim = reg_wdata_i & AMRS_ETIM_MASK;
        default: ;
      endcase
    end

    // sequencer
    if (start) begin
      state_next.addr     = reg_wdata_i[AW-1:0];
      state_next.bank     = reg_wdata_i[AMRS_ADDR_BANK_LSB +: BW];
      state_next.be       = state_reg.ctl[AMRS_CTL_BE_LSB +: BEW];
      state_next.flash    = state_reg.ctl[AMRS_CTL_MODE_LSB +: 2] == AMRS_MODE_FLASH;
      state_next.rdy_en   = state_reg.ctl[AMRS_CTL_RDYEN_BIT];
      state_next.rdy_seen = 1'b0;
      state_next.pre      = state_reg.etim[AMRS_ETIM_PRE_LSB +: CW];
      state_next.pac      = state_reg.etim[AMRS_ETIM_PAC_LSB +: CW];
      state_next.set      = state_reg.tim[AMRS_TIM_SET_LSB +: CW];
      state_next.hld      = state_reg.tim[AMRS_TIM_HLD_LSB +: CW];
      state_next.acc      = state_reg.tim[AMRS_TIM_ACC_LSB +: CW];
      if (state_next.acc == '0) begin
        state_next.acc = CW'(1);
      end
      state_next.ph  = next_live(AMRS_IDLE, state_next.pre, state_next.set,
                                 state_next.pac, state_next.hld);
      state_next.cnt = phase_last(state_next.ph, state_next);
    end else if (state_reg.ph != AMRS_IDLE) begin
      if (state_reg.ph == AMRS_ACCESS && ready_sync) begin
        state_next.rdy_seen = 1'b1;
      end
      if (state_reg.cnt != '0) begin
        state_next.cnt = state_reg.cnt - CW'(1);
      end else if (!(state_reg.ph == AMRS_ACCESS && state_reg.rdy_en && !state_reg.rdy_seen)) begin
        state_next.ph  = next_live(state_reg.ph, state_reg.pre, state_reg.set,
                                   state_reg.pac, state_reg.hld);
        state_next.cnt = phase_last(state_next.ph, state_reg);
        if (state_reg.ph == AMRS_ACCESS) begin
          state_next.cap[0] = 1'b1;
        end
      end
    end

    // read data capture; a capture beats a clearing read
    if (reg_read_i && reg_addr_i == AMRS_OFF_DATA) begin
      state_next.valid = 1'b0;
    end
    if (state_reg.cap[1]) begin
      state_next.data  = data_sync;
      state_next.valid = 1'b1;
    end

    // pin drive from the coming phase
    state_next.rd_n  = state_next.ph != AMRS_ACCESS;
    state_next.oe_n  = !(state_next.ph == AMRS_SETUP || state_next.ph == AMRS_PREACCESS ||
                         state_next.ph == AMRS_ACCESS || state_next.ph == AMRS_HOLD);
    state_next.adv_n = !(state_next.flash && state_next.ph == AMRS_SETUP);
    if (state_next.ph != AMRS_IDLE) begin
      state_next.bank_n = ~({{(NB-1){1'b0}}, 1'b1} << state_next.bank);
      state_next.be_n   = ~state_next.be;
    end else begin
      state_next.bank_n = '1;
      state_next.be_n   = '1;
    end
    state_next.clk_en = state_reg.ctl[AMRS_CTL_CLKSEL_LSB +: 4] == AMRS_CLKSEL_SYS;

    // register reads
    if (reg_read_i) begin
      case (reg_addr_i)
        AMRS_OFF_CTL:  state_next.rdata = state_reg.ctl;
        AMRS_OFF_TIM:  state_next.rdata = state_reg.tim;
        AMRS_OFF_ETIM: state_next.rdata = state_reg.etim;
        AMRS_OFF_ADDR: begin
          state_next.rdata[AW-1:0]                     = state_reg.addr;
          state_next.rdata[AMRS_ADDR_BANK_LSB +: BW]   = state_reg.bank;
        end
        AMRS_OFF_DATA: state_next.rdata[DW-1:0] = state_reg.data;
        AMRS_OFF_STAT: begin
          state_next.rdata[AMRS_STAT_BUSY_BIT]      = state_reg.ph != AMRS_IDLE;
          state_next.rdata[AMRS_STAT_VALID_BIT]     = state_reg.valid;
          state_next.rdata[AMRS_STAT_PH_LSB +: 3]   = state_reg.ph;
        end
        default: state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg        <= '0;
      state_reg.ctl    <= AMRS_CTL_RST;
      state_reg.tim    <= AMRS_TIM_RST;
      state_reg.etim   <= AMRS_ETIM_RST;
      state_reg.ph     <= AMRS_IDLE;
      state_reg.rd_n   <= 1'b1;
      state_reg.oe_n   <= 1'b1;
      state_reg.adv_n  <= 1'b1;
      state_reg.bank_n <= '1;
      state_reg.be_n   <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o          = state_reg.rdata;
  assign memory_address_out_o = state_reg.addr;
  assign bank_select_n_o      = state_reg.bank_n;
  assign byte_enable_n_o      = state_reg.be_n;
  assign output_enable_n_o    = state_reg.oe_n;
  assign read_strobe_n_o      = state_reg.rd_n;
  assign address_valid_n_o    = state_reg.adv_n;
  // gated copy of the system clock; a select change may cut the pulse at its switching edge
  assign clock_output_pin_o   = sys_clk_i & state_reg.clk_en;

  // helper counters for the checks below
  logic [HW-1:0] lead_cnt;
  logic [HW-1:0] oe_cnt;
  logic [HW-1:0] adv_lo_cnt;
  logic [HW-1:0] adv_hi_cnt;
  logic [HW-1:0] low_cnt;
  logic [HW-1:0] hold_cnt;
  logic          strobe_done;
  logic [HW-1:0] lead_sum;

  assign lead_sum = HW'(state_reg.pre) + HW'(state_reg.set) + HW'(state_reg.pac);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lead_cnt    <= '0;
      oe_cnt      <= '0;
      adv_lo_cnt  <= '0;
      adv_hi_cnt  <= '0;
      low_cnt     <= '0;
      hold_cnt    <= '0;
      strobe_done <= 1'b0;
    end else begin
      lead_cnt    <= (&bank_select_n_o) ? '0 : (read_strobe_n_o ? lead_cnt + HW'(1) : lead_cnt);
      oe_cnt      <= output_enable_n_o ? '0 : (read_strobe_n_o ? oe_cnt + HW'(1) : oe_cnt);
      adv_lo_cnt  <= address_valid_n_o ? '0 : adv_lo_cnt + HW'(1);
      adv_hi_cnt  <= address_valid_n_o ? adv_hi_cnt + HW'(1) : '0;
      low_cnt     <= read_strobe_n_o ? '0 : low_cnt + HW'(1);
      hold_cnt    <= ((&bank_select_n_o) || !read_strobe_n_o) ? '0 :
                     (strobe_done ? hold_cnt + HW'(1) : hold_cnt);
      strobe_done <= (&bank_select_n_o) ? 1'b0 : (strobe_done | !read_strobe_n_o);
    end
  end

  a_select_lead: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(read_strobe_n_o) |-> lead_cnt == lead_sum)
    else $error("select lead before strobe wrong");

  a_oe_lead: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(read_strobe_n_o) |-> oe_cnt == HW'(state_reg.set) + HW'(state_reg.pac))
    else $error("output enable lead before strobe wrong");

  a_strobe_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(read_strobe_n_o) && !state_reg.rdy_en |-> low_cnt == HW'(state_reg.acc))
    else $error("strobe low width differs from access count");

  a_hold_length: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(&bank_select_n_o) && strobe_done |-> hold_cnt == HW'(state_reg.hld))
    else $error("hold phase length wrong");

  a_hold_stable: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    strobe_done && read_strobe_n_o && !(&bank_select_n_o) |->
      $stable(memory_address_out_o) && $stable(byte_enable_n_o) && $stable(bank_select_n_o) &&
      !output_enable_n_o)
    else $error("outputs moved during hold");

  a_ready_release: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg.ph == AMRS_ACCESS && state_reg.rdy_en && state_reg.rdy_seen && state_reg.cnt == '0
      |=> read_strobe_n_o)
    else $error("strobe not released after ready");

  a_ready_wait: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(read_strobe_n_o) && state_reg.rdy_en |-> $past(ready_sync, 2) && low_cnt >= HW'(state_reg.acc))
    else $error("strobe released without ready");

  a_adv_lead: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(address_valid_n_o) |-> lead_cnt == HW'(state_reg.pre))
    else $error("select lead before address valid wrong");

  a_adv_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(address_valid_n_o) |-> adv_lo_cnt == HW'(state_reg.set))
    else $error("address valid width wrong");

  a_adv_to_strobe: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(read_strobe_n_o) && state_reg.flash && state_reg.set != '0 |->
      adv_hi_cnt == HW'(state_reg.pac))
    else $error("strobe delay after address valid wrong");

  a_clock_select: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg.ctl[AMRS_CTL_CLKSEL_LSB +: 4] == AMRS_CLKSEL_SYS |=> state_reg.clk_en)
    else $error("clock output not enabled by select");

  a_sram_no_adv: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !state_reg.flash |-> address_valid_n_o)
    else $error("address valid driven in sram mode");

  a_phase_order: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg.ph == AMRS_HOLD |=> state_reg.ph == AMRS_HOLD || state_reg.ph == AMRS_IDLE)
    else $error("phase order broken after hold");

  a_idle_pins: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg.ph == AMRS_IDLE |-> (&bank_select_n_o) && read_strobe_n_o && output_enable_n_o)
    else $error("memory pins active while idle");

  a_adv_in_frame: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !address_valid_n_o |-> !(&bank_select_n_o) && read_strobe_n_o)
    else $error("address valid outside select or beside strobe");

endmodule // amrs_read_seq

// file: rtl/amrs_pkg.sv
// Purpose: shared constants and types of the asynchronous memory read sequencer
// Assumes: 32-bit register words on a plain strobe port, byte offsets
// Notes:   counts are in system clock 0 cycles
package amrs_pkg;

  // clock
  localparam int unsigned AMRS_CLK_PERIOD_NS  = 10;
  localparam int unsigned AMRS_SYNC_STAGES    = 2;

  // register port
  localparam int unsigned AMRS_REG_AW         = 8;
  localparam int unsigned AMRS_REG_DW         = 32;

  // register offsets
  localparam logic [7:0]  AMRS_OFF_CTL        = 8'h00;
  localparam logic [7:0]  AMRS_OFF_TIM        = 8'h04;
  localparam logic [7:0]  AMRS_OFF_ETIM       = 8'h08;
  localparam logic [7:0]  AMRS_OFF_ADDR       = 8'h0c;
  localparam logic [7:0]  AMRS_OFF_DATA       = 8'h10;
  localparam logic [7:0]  AMRS_OFF_STAT       = 8'h14;

  // control register fields
  localparam int unsigned AMRS_CTL_MODE_LSB   = 0;
  localparam int unsigned AMRS_CTL_RDYEN_BIT  = 2;
  localparam int unsigned AMRS_CTL_CLKSEL_LSB = 4;
  localparam int unsigned AMRS_CTL_BE_LSB     = 8;
  localparam logic [31:0] AMRS_CTL_MASK       = 32'h0000_0ff7;
  localparam logic [31:0] AMRS_CTL_RST        = 32'h0000_0f00;

  // timing register fields
  localparam int unsigned AMRS_TIM_SET_LSB    = 0;
  localparam int unsigned AMRS_TIM_ACC_LSB    = 8;
  localparam int unsigned AMRS_TIM_HLD_LSB    = 16;
  localparam logic [31:0] AMRS_TIM_MASK       = 32'h00ff_ffff;
  localparam logic [31:0] AMRS_TIM_RST        = 32'h0001_0401;

  // extended timing register fields
  localparam int unsigned AMRS_ETIM_PRE_LSB   = 0;
  localparam int unsigned AMRS_ETIM_PAC_LSB   = 8;
  localparam logic [31:0] AMRS_ETIM_MASK      = 32'h0000_ffff;
  localparam logic [31:0] AMRS_ETIM_RST       = 32'h0000_0000;

  // address register and status fields
  localparam int unsigned AMRS_ADDR_BANK_LSB  = 24;
  localparam int unsigned AMRS_STAT_BUSY_BIT  = 0;
  localparam int unsigned AMRS_STAT_VALID_BIT = 1;
  localparam int unsigned AMRS_STAT_PH_LSB    = 4;

  // encodings
  localparam logic [1:0]  AMRS_MODE_SRAM      = 2'h0;
  localparam logic [1:0]  AMRS_MODE_FLASH     = 2'h1;
  localparam logic [3:0]  AMRS_CLKSEL_SYS     = 4'h3;

  typedef enum logic [2:0] {
    AMRS_IDLE      = 3'b000,
    AMRS_PRESETUP  = 3'b001,
    AMRS_SETUP     = 3'b010,
    AMRS_PREACCESS = 3'b011,
    AMRS_ACCESS    = 3'b100,
    AMRS_HOLD      = 3'b101
  } amrs_phase_t;

endpackage

// file: rtl/amrs_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to sys_clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module amrs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  import amrs_pkg::*;

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } amrs_sync_t;

  amrs_sync_t sync_reg;
  amrs_sync_t sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = async_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg.s2;

endmodule // amrs_sync

// file: bench/amrs_mem_model.sv
// Purpose: asynchronous memory seen from the read sequencer pins
// Assumes: data word is address xor 16'h5a5a
// Notes:   released data bus shows the inverse of its last value
`timescale 1ns/1ns
module amrs_mem_model #(
  parameter int unsigned AW = 24,
  parameter int unsigned DW = 16,
  parameter int unsigned NB = 4
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic [AW-1:0] memory_address_out_i,
  input  wire logic [NB-1:0] bank_select_n_i,
  input  wire logic          output_enable_n_i,
  input  wire logic          read_strobe_n_i,
  input  wire logic [7:0]    ready_delay_i,
  output logic      [DW-1:0] memory_data_bus_o,
  output logic               memory_ready_in_o
);
  logic [7:0] wait_cnt;
  logic [1:0] keep_cnt;

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      memory_ready_in_o <= 1'b0;
      wait_cnt          <= 8'h00;
      keep_cnt          <= 2'h0;
      memory_data_bus_o <= '0;
    end else begin
      // ready low from strobe fall, high after the chosen delay
      if (read_strobe_n_i) begin
        memory_ready_in_o <= 1'b0;
        wait_cnt          <= 8'h00;
      end else if (wait_cnt >= ready_delay_i) begin
        memory_ready_in_o <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
      // data held a few cycles after output enable goes away
      if (!output_enable_n_i && !(&bank_select_n_i)) begin
        memory_data_bus_o <= memory_address_out_i[DW-1:0] ^ 16'h5a5a;
        keep_cnt          <= 2'h3;
      end else if (keep_cnt != 2'h0) begin
        keep_cnt <= keep_cnt - 2'h1;
      end else begin
        memory_data_bus_o <= ~memory_data_bus_o;
      end
    end
  end
endmodule // amrs_mem_model

// file: bench/amrs_read_seq_tb.sv
// Purpose: self-checking bench of the read sequencer
// Assumes: memory model on the pin side, register port driven by tasks
// Notes:   phase edges are counted at the falling clock edge
`timescale 1ns/1ns
module amrs_read_seq_tb;
  import amrs_pkg::*;
  logic        sys_clk_i   = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i  = 1'b0;
  logic [7:0]  rdy_delay   = 8'h00;
  logic [31:0] reg_rdata_o;
  logic [23:0] mem_addr;
  logic [3:0]  bank_n;
  logic [1:0]  be_n;
  logic        oe_n;
  logic        rd_n;
  logic        adv_n;
  logic        rdy;
  logic        clk_out;
  logic [15:0] mem_data;
  logic [31:0] d;
  logic [3:0]  p_bank     = 4'hf;
  logic        p_oe       = 1'b1;
  logic        p_rd       = 1'b1;
  logic        p_adv      = 1'b1;
  logic [23:0] p_addr;
  logic [5:0]  sel_at_rd;
  logic [23:0] addr_at_rd;
  logic [23:0] addr_at_end;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          t_bf, t_br, t_of, t_or, t_af, t_ar, t_rf, t_rr;
  realtime     t_rdy, t_rise;

  always #5 sys_clk_i = ~sys_clk_i;

  amrs_read_seq dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .memory_address_out_o(mem_addr), .bank_select_n_o(bank_n),
    .byte_enable_n_o(be_n), .output_enable_n_o(oe_n), .read_strobe_n_o(rd_n),
    .address_valid_n_o(adv_n), .memory_data_bus_i(mem_data), .memory_ready_in_i(rdy),
    .clock_output_pin_o(clk_out));

  amrs_mem_model mem (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .memory_address_out_i(mem_addr),
    .bank_select_n_i(bank_n), .output_enable_n_i(oe_n), .read_strobe_n_i(rd_n),
    .ready_delay_i(rdy_delay), .memory_data_bus_o(mem_data), .memory_ready_in_o(rdy));

  // pin edge monitor
  always @(negedge sys_clk_i) begin
    cyc = cyc + 1;
    if (p_bank == 4'hf && bank_n != 4'hf) t_bf = cyc;
    if (p_bank != 4'hf && bank_n == 4'hf) begin
      t_br        = cyc;
      addr_at_end = p_addr;
    end
    if (p_oe && !oe_n) t_of = cyc;
    if (!p_oe && oe_n) t_or = cyc;
    if (p_adv && !adv_n) t_af = cyc;
    if (!p_adv && adv_n) t_ar = cyc;
    if (p_rd && !rd_n) begin
      t_rf       = cyc;
      sel_at_rd  = {bank_n, be_n};
      addr_at_rd = mem_addr;
    end
    if (!p_rd && rd_n) t_rr = cyc;
    p_bank = bank_n;
    p_oe   = oe_n;
    p_rd   = rd_n;
    p_adv  = adv_n;
    p_addr = mem_addr;
  end
  always @(posedge rdy) t_rdy = $realtime;
  always @(posedge rd_n) t_rise = $realtime;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_write_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask

  task automatic wait_idle();
    int i;
    d = 32'h1;
    for (i = 0; i < 100 && d[AMRS_STAT_BUSY_BIT] !== 1'b0; i++) reg_rd(AMRS_OFF_STAT, d);
    if (d[AMRS_STAT_BUSY_BIT] !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    reg_rd(AMRS_OFF_CTL, d);
    chk(d, AMRS_CTL_RST);
    reg_rd(AMRS_OFF_TIM, d);
    chk(d, AMRS_TIM_RST);
    reg_rd(AMRS_OFF_ETIM, d);
    chk(d, AMRS_ETIM_RST);
    reg_wr(8'h1c, 32'hffff_ffff);
    reg_rd(8'h1c, d);
    chk(d, 32'h0);
    // sram read: pre 2, setup 3, preaccess 1, access 4, hold 2
    reg_wr(AMRS_OFF_TIM, 32'h0002_0403);
    reg_wr(AMRS_OFF_ETIM, 32'h0000_0102);
    reg_wr(AMRS_OFF_CTL, 32'h0000_0f00);
    reg_wr(AMRS_OFF_ADDR, 32'h0212_3456);
    wait_idle();
    chk(t_rf - t_bf, 6);
    chk(t_rf - t_of, 4);
    chk(t_rr - t_rf, 4);
    chk(t_br - t_rr, 2);
    chk(t_or, t_br);
    chk(addr_at_end, addr_at_rd);
    chk({sel_at_rd, addr_at_rd}, {6'h2c, 24'h123456});
    chk(t_af, 0);
    reg_rd(AMRS_OFF_STAT, d);
    chk(d, 32'h1 << AMRS_STAT_VALID_BIT);
    reg_rd(AMRS_OFF_DATA, d);
    chk(d, 32'h6e0c);
    reg_rd(AMRS_OFF_STAT, d);
    chk(d, 32'h0);
    // flash read, second start while busy is refused
    reg_wr(AMRS_OFF_CTL, 32'h0000_0301);
    reg_wr(AMRS_OFF_ADDR, 32'h0100_00ff);
    reg_wr(AMRS_OFF_ADDR, 32'h0300_0001);
    wait_idle();
    chk(t_af - t_bf, 2);
    chk(t_ar - t_af, 3);
    chk(t_rf - t_ar, 1);
    chk(t_rr - t_rf, 4);
    chk(t_br - t_rr, 2);
    chk(sel_at_rd, 6'h34);
    reg_rd(AMRS_OFF_ADDR, d);
    chk(d, 32'h0100_00ff);
    reg_rd(AMRS_OFF_DATA, d);
    chk(d, 32'h5aa5);
    // ready stretches the access
    rdy_delay <= 8'h08;
    reg_wr(AMRS_OFF_CTL, 32'h0000_0104);
    reg_wr(AMRS_OFF_ADDR, 32'h0000_0010);
    wait_idle();
    chk({31'h0, (t_rise - t_rdy >= 25.0) && (t_rise - t_rdy <= 52.5)}, 32'h1);
    chk(t_rr - t_rf > 4, 1);
    chk(sel_at_rd, 6'h3a);
    reg_rd(AMRS_OFF_DATA, d);
    chk(d, 32'h5a4a);
    // clock output
    reg_wr(AMRS_OFF_CTL, 32'h0000_0030);
    repeat (3) @(posedge sys_clk_i);
    #2;
    chk(clk_out, 1'b1);
    #5;
    chk(clk_out, 1'b0);
    reg_wr(AMRS_OFF_CTL, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    #2;
    chk(clk_out, 1'b0);
    wrap_up();
  end
endmodule // amrs_read_seq_tb
